// ### hdl/acf_convert.sv
// Conversion sequencer with over-temperature flag and data output enable
`timescale 1ns/1ns
`default_nettype none
`include "acf_map.svh"

module acf_convert
    import acf_pkg::*;
#(
    parameter int RES_W = `ACF_RES_W,
    parameter int THR_W = `ACF_THR_W
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic                  conversion_trigger_n,
    input  wire logic [`ACF_CH_W-1:0]  channel_sel,
    input  wire logic [RES_W-1:0]      sample_code,
    input  wire logic [THR_W-1:0]      overtemp_threshold_word,
    input  wire acf_port_t             port_in,
    output logic                       busy,
    output logic                       track_hold,
    output logic                       powered_down,
    output logic [RES_W-1:0]           result,
    output logic                       overtemp_flag_n,
    output logic                       dout_oe
);

    localparam int VOLT_CYC = `ACF_CONV_VOLT_CYC;
    localparam int TEMP_CYC = `ACF_CONV_TEMP_CYC;

    // Every assertion below lives in the system clock domain
    default clocking acf_cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    if (RES_W != `ACF_RES_W || THR_W != `ACF_THR_W ||
        THR_W > RES_W || `ACF_BUSY_RISE_CYC < 1 ||
        TEMP_CYC >= (1 << `ACF_CNT_W)) begin : g_bad_cfg
        $error("acf_convert: unsupported parameter set");
    end

    acf_regs_t regs_ff;
    acf_regs_t nxt_regs;

    logic                  trig_fall;
    logic                  conv_end;
    logic                  rdwr_rise;
    logic                  rdwr_fall;
    logic                  cs_rise;
    logic                  ot_hit;
    logic [`ACF_CNT_W-1:0] conv_last;

    // Inputs are synchronous, so edges are found against the last sample
    assign trig_fall = regs_ff.trig_q && !conversion_trigger_n;
    assign rdwr_rise = port_in.rd_wr && !regs_ff.port_q.rd_wr;
    assign rdwr_fall = !port_in.rd_wr && regs_ff.port_q.rd_wr;
    assign cs_rise   = port_in.port_select_n &&
                       !regs_ff.port_q.port_select_n;
    // Temperature takes the long slot, voltage channels the short one
    assign conv_last = regs_ff.is_temp ?
                       `ACF_CNT_W'(TEMP_CYC - 1) :
                       `ACF_CNT_W'(VOLT_CYC - 1);
    assign conv_end  = (regs_ff.st == ACF_ST_CONV) &&
                       (regs_ff.cnt == conv_last);
    // Only the top byte is compared; lower two bits are sub-degree
    assign ot_hit    = sample_code[RES_W-1 -: THR_W] >
                       overtemp_threshold_word;

    always_comb begin
        nxt_regs        = regs_ff;
        nxt_regs.trig_q = conversion_trigger_n;
        nxt_regs.port_q = port_in;
        unique case (regs_ff.st)
            ACF_ST_TRACK: begin
                if (trig_fall) begin
                    nxt_regs.st      = ACF_ST_CONV;
                    nxt_regs.cnt     = '0;
                    nxt_regs.is_temp =
                        (channel_sel == `ACF_TEMP_CHANNEL);
                end
            end
            ACF_ST_CONV: begin
                if (conv_end) begin
                    nxt_regs.result = sample_code;
                    // Low trigger at the end means sleep until it rises
                    nxt_regs.st = conversion_trigger_n ?
                                  ACF_ST_TRACK : ACF_ST_DOWN;
                end else begin
                    nxt_regs.cnt = regs_ff.cnt + `ACF_CNT_W'(1);
                end
            end
            ACF_ST_DOWN: begin
                if (conversion_trigger_n) begin
                    nxt_regs.st = ACF_ST_TRACK;
                end
            end
            default: begin
                nxt_regs.st = ACF_ST_TRACK;
            end
        endcase

        // Clear first so that a new hit in the same cycle wins
        if (rdwr_rise && !port_in.port_select_n) begin
            nxt_regs.ot_flag_n = 1'h1;
        end
        if (conv_end && regs_ff.is_temp && ot_hit) begin
            nxt_regs.ot_flag_n = 1'h0;
        end

        if (port_in.port_select_n || cs_rise || rdwr_fall) begin
            nxt_regs.dout_oe = 1'h0;
        end else if (rdwr_rise) begin
            nxt_regs.dout_oe = 1'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regs_ff.st        <= ACF_ST_TRACK;
            regs_ff.cnt       <= '0;
            regs_ff.is_temp   <= 1'h0;
            regs_ff.trig_q    <= 1'h1;
            regs_ff.port_q    <= '{port_select_n: 1'h1, rd_wr: 1'h0};
            regs_ff.result    <= '0;
            regs_ff.ot_flag_n <= 1'h1;
            regs_ff.dout_oe   <= 1'h0;
        end else if (clk_en) begin
            regs_ff <= nxt_regs;
        end
    end

    // Busy rises one edge after the fall is seen, well inside 50 ns
    assign busy            = (regs_ff.st == ACF_ST_CONV);
    assign track_hold      = (regs_ff.st == ACF_ST_CONV);
    assign powered_down    = (regs_ff.st == ACF_ST_DOWN);
    assign result          = regs_ff.result;
    assign overtemp_flag_n = regs_ff.ot_flag_n;
    assign dout_oe         = regs_ff.dout_oe;

    a_start_busy: assert property (
        clk_en && trig_fall && regs_ff.st == ACF_ST_TRACK
        |=> busy && track_hold)
        else $error("conversion did not start on trigger fall");

    a_busy_fast: assert property (
        clk_en && trig_fall && regs_ff.st == ACF_ST_TRACK
        |=> $rose(busy))
        else $error("busy late after trigger fall");

    a_track_back: assert property (
        clk_en && conv_end |=> !busy && !track_hold)
        else $error("hold not released at conversion end");

    a_down_low: assert property (
        clk_en && conv_end && !conversion_trigger_n
        |=> powered_down)
        else $error("no power down with trigger low");

    a_stay_up: assert property (
        clk_en && conv_end && conversion_trigger_n
        |=> !powered_down && !busy)
        else $error("powered down with trigger high");

    a_conv_bound: assert property (
        busy |-> regs_ff.cnt <= conv_last)
        else $error("conversion ran past its time");

    a_ot_set: assert property (
        clk_en && conv_end && regs_ff.is_temp && ot_hit
        |=> !overtemp_flag_n)
        else $error("flag not set on hot result");

    a_ot_equal: assert property (
        clk_en && conv_end && overtemp_flag_n &&
        sample_code[RES_W-1 -: THR_W] == overtemp_threshold_word
        |=> overtemp_flag_n)
        else $error("flag set on equal result");

    a_ot_clear: assert property (
        clk_en && rdwr_rise && !port_in.port_select_n && !conv_end
        |=> overtemp_flag_n)
        else $error("flag not released by read end");

    a_dout_float: assert property (
        clk_en && (port_in.port_select_n || rdwr_fall)
        |=> !dout_oe)
        else $error("data output driven while deselected");

    // Busy, sleep and the flag may only move on their own events; a selected read enables the data output
    a_busy_source: assert property (
        !busy && !(clk_en && trig_fall && regs_ff.st == ACF_ST_TRACK)
        |=> !busy)
        else $error("busy rose without an accepted trigger fall");

    a_busy_hold: assert property (
        busy && !(clk_en && conv_end)
        |=> busy)
        else $error("busy dropped before conversion end");

    a_down_hold: assert property (
        powered_down && !conversion_trigger_n
        |=> powered_down)
        else $error("woke up while trigger still low");

    a_flag_hold: assert property (
        !overtemp_flag_n && !(clk_en && rdwr_rise && !port_in.port_select_n)
        |=> !overtemp_flag_n)
        else $error("flag released without a selected read end");

    a_dout_set: assert property (
        clk_en && rdwr_rise && !port_in.port_select_n
        |=> dout_oe)
        else $error("data output not enabled on selected read");

    c_temp_hot: cover property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && conv_end && regs_ff.is_temp && ot_hit);
    c_volt_conv: cover property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && conv_end && !regs_ff.is_temp);
    c_power_down: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(powered_down));
    c_read_clear: cover property (@(posedge sys_clk) disable iff (!resetn)
        $rose(overtemp_flag_n));
    c_retrig_refused: cover property (@(posedge sys_clk) disable iff (!resetn)
        clk_en && trig_fall && busy);

endmodule

`default_nettype wire

// ### include/acf_map.svh
// Constants for the conversion and over-temperature flag block
// Functional notes
// - Trigger falling edge starts 10-bit conversion
// - Hold on trigger fall, track after completion
// - Trigger low at completion powers device down
// - Busy high exactly during any conversion
// - Temperature result above threshold pulls flag low
// - Read/write rise with select low releases flag
// - Serial port answers only while selected
// - Voltage 9 us, temperature 27 us conversions
// - Busy rises within 50 ns of trigger
// - Data output floats on read/write fall, select rise
`ifndef ACF_MAP_SVH
`define ACF_MAP_SVH

`define ACF_CLK_PERIOD_NS   10
`define ACF_T_CONV_VOLT_NS  9000
`define ACF_T_CONV_TEMP_NS  27000
`define ACF_T_BUSY_RISE_NS  50
`define ACF_CONV_VOLT_CYC   (`ACF_T_CONV_VOLT_NS / `ACF_CLK_PERIOD_NS)
`define ACF_CONV_TEMP_CYC   (`ACF_T_CONV_TEMP_NS / `ACF_CLK_PERIOD_NS)
`define ACF_BUSY_RISE_CYC   (`ACF_T_BUSY_RISE_NS / `ACF_CLK_PERIOD_NS)
`define ACF_RES_W           10
`define ACF_THR_W           8
`define ACF_CNT_W           12
`define ACF_CH_W            3
`define ACF_TEMP_CHANNEL    3'h0

`endif

// ### include/acf_pkg.sv
// Types shared by the conversion and over-temperature flag block
`default_nettype none
`include "acf_map.svh"

package acf_pkg;

    // Sequence: track -> convert -> powered down -> track; down to track flips both bits
    typedef enum logic [1:0] {
        ACF_ST_TRACK = 2'h0,
        ACF_ST_CONV  = 2'h1,
        ACF_ST_DOWN  = 2'h3
    } acf_state_t;

    typedef struct packed {
        logic port_select_n;
        logic rd_wr;
    } acf_port_t;

    typedef struct packed {
        acf_state_t                st;
        logic [`ACF_CNT_W-1:0]     cnt;
        logic                      is_temp;
        logic                      trig_q;
        acf_port_t                 port_q;
        logic [`ACF_RES_W-1:0]     result;
        logic                      ot_flag_n;
        logic                      dout_oe;
    } acf_regs_t;

endpackage

`default_nettype wire

// ### bench/acf_host_model.sv
// Host model driving convert start and the serial port select lines
`timescale 1ns/1ns
`default_nettype none
module acf_host_model
    import acf_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     busy,
    input  wire logic     dout_oe,
    output var  logic     conversion_trigger_n,
    output var  acf_port_t port_in
);
    initial begin
        conversion_trigger_n = 1'h1;
        port_in = '{1'h1, 1'h0};
    end
    task automatic drive(input logic v);
        @(posedge sys_clk) #1 conversion_trigger_n = v;
    endtask
    // Busy falling is taken as the conversion-complete event
    task automatic wait_done(output logic [15:0] n);
        n = 16'h0000;
        while (busy === 1'h1 && n < 16'h1000) begin
            n = n + 16'h0001;
            @(posedge sys_clk) #1;
        end
    endtask
    // Select gates the port so other parts can share the bus
    task automatic read(input logic sel, input logic first,
                        output logic oe_mid, output logic oe_end);
        @(posedge sys_clk) #1 port_in.port_select_n = !sel;
        @(posedge sys_clk) #1 port_in.rd_wr = 1'h1;
        @(posedge sys_clk) #1 oe_mid = dout_oe;
        if (first)
            port_in.port_select_n = 1'h1;
        else
            port_in.rd_wr = 1'h0;
        @(posedge sys_clk) #1 oe_end = dout_oe;
        port_in = '{1'h1, 1'h0};
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the conversion and over-temperature block
`timescale 1ns/1ns
`default_nettype none
`include "acf_map.svh"
module tb;
    import acf_pkg::*;
    logic        sys_clk = 1'h0;
    logic        resetn, clk_en, conversion_trigger_n, busy, track_hold;
    logic        powered_down, overtemp_flag_n, dout_oe, flag_exp;
    logic [2:0]  channel_sel, ch;
    logic [9:0]  sample_code, result, code;
    logic [7:0]  overtemp_threshold_word, thr;
    acf_port_t   port_in;
    int          seed = 55910;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    acf_convert u_acf_convert (
        .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
        .conversion_trigger_n(conversion_trigger_n),
        .channel_sel(channel_sel), .sample_code(sample_code),
        .overtemp_threshold_word(overtemp_threshold_word),
        .port_in(port_in), .busy(busy), .track_hold(track_hold),
        .powered_down(powered_down), .result(result),
        .overtemp_flag_n(overtemp_flag_n), .dout_oe(dout_oe));
    acf_host_model u_acf_host_model (
        .sys_clk(sys_clk), .busy(busy), .dout_oe(dout_oe),
        .conversion_trigger_n(conversion_trigger_n), .port_in(port_in));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic logic [15:0] exp_cyc(input logic [2:0] c);
        return (c == `ACF_TEMP_CHANNEL) ? 16'(`ACF_CONV_TEMP_CYC)
                                        : 16'(`ACF_CONV_VOLT_CYC);
    endfunction
    function automatic logic is_hot(input logic [2:0] c,
                                    input logic [9:0] v, input logic [7:0] t);
        return c == `ACF_TEMP_CHANNEL && v[9:2] > t;
    endfunction

    // Low leaves the trigger low so the conversion ends in power down
    // Extra disturbs the run: a retrigger, then a frozen clock enable
    task automatic conv(input logic low, input logic [15:0] extra);
        logic [15:0] n;
        channel_sel = ch;
        sample_code = code;
        overtemp_threshold_word = thr;
        u_acf_host_model.drive(1'h0);
        u_acf_host_model.drive(!low);
        check1(busy, 1'h1);
        check1(track_hold, 1'h1);
        fork
            u_acf_host_model.wait_done(n);
            if (extra != 16'h0000) begin
                repeat (50) @(posedge sys_clk);
                u_acf_host_model.drive(1'h0);
                u_acf_host_model.drive(1'h1);
                clk_en = 1'h0;
                repeat (20) @(posedge sys_clk);
                #1 clk_en = 1'h1;
            end
        join
        check(n, exp_cyc(ch) + extra);
        check1(track_hold, 1'h0);
        check({6'h00, result}, {6'h00, code});
        check1(powered_down, low);
        if (is_hot(ch, code, thr))
            flag_exp = 1'h0;
        check1(overtemp_flag_n, flag_exp);
    endtask
    task automatic rd(input logic sel, input logic first);
        logic m;
        logic e;
        u_acf_host_model.read(sel, first, m, e);
        check1(m, sel);
        check1(e, 1'h0);
        if (sel)
            flag_exp = 1'h1;
        check1(overtemp_flag_n, flag_exp);
    endtask

    initial begin
        resetn = 1'h0;
        clk_en = 1'h1;
        channel_sel = 3'h0;
        sample_code = 10'h000;
        overtemp_threshold_word = 8'h00;
        flag_exp = 1'h1;
        repeat (6) @(posedge sys_clk);
        #1 resetn = 1'h1;
        check({1'h0, busy, track_hold, powered_down, result,
               overtemp_flag_n, dout_oe}, 16'h0002);
        for (int i = 0; i < 12; i++) begin
            ch = ($random(seed) & 1) ? 3'h0 : 3'($random(seed));
            code = 10'($random(seed));
            thr = 8'($random(seed));
            if (i == 0) begin
                ch = 3'h0;
                thr = code[9:2];
            end
            if (i > 0 && i < 3) begin
                code = 10'h3FF;
                thr = 8'hFE;
                ch = 3'(i - 1);
            end
            conv(i == 3, (i == 4) ? 16'h0014 : 16'h0000);
            if (i == 3) begin
                u_acf_host_model.drive(1'h1);
                @(posedge sys_clk) #1;
                check1(powered_down, 1'h0);
            end
            rd(!i[0], i[1]);
            $display("test %0d done", i);
        end
        results();
    end
endmodule
`default_nettype wire
